// *** src/mid_defines.svh ***
`ifndef MID_DEFINES_SVH
`define MID_DEFINES_SVH

// Word layout
`define MID_TOP 15:12
`define MID_SUB 11:8
`define MID_D_BIT 9
`define MID_A_BIT 8
`define MID_F 7:0
`define MID_B 11:9
`define MID_K 7:0
`define MID_KHI 3:0
`define MID_PTR 5:4
`define MID_N 10:0
`define MID_N_MSB 10
`define MID_FS 11:0
`define MID_MM 1:0
`define MID_CALL_S 8
`define MID_RET_S 0

// Opcode groups by top nibble
`define MID_OP_CTRL 4'h0
`define MID_OP_BYTE_LO 4'h1
`define MID_OP_BYTE_HI 4'h5
`define MID_OP_LPTR 4'h6
`define MID_OP_BIT_LO 4'h7
`define MID_OP_BTEST 4'hA
`define MID_OP_LIT 4'hB
`define MID_OP_MOVE 4'hC
`define MID_OP_BRA 4'hD
`define MID_OP_CALL 4'hE
`define MID_CONT 4'hF
`define MID_SUB_TBL 4'h1
`define MID_SUB_RET 4'h2

// Reset / flush word and fixed bank
`define MID_NOP_WORD 16'hFFFF
`define MID_ACC_BANK 4'h0
`define MID_ZERO4 4'h0

// Instruction cycle phases
`define MID_PHASES 4
`define MID_PH_Q1 2'h0
`define MID_PH_Q2 2'h1
`define MID_PH_Q3 2'h2
`define MID_PH_Q4 2'h3

`endif

// *** src/mid_pkg.sv ***
package mid_pkg;
`include "mid_defines.svh"

typedef enum logic [1:0] {
    CLS_BYTE = 2'b00,
    CLS_BIT = 2'b01,
    CLS_LIT = 2'b10,
    CLS_CTRL = 2'b11
} mid_class_e;

typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_WORD2 = 2'b01,
    ST_FLUSH = 2'b10
} mid_state_e;

typedef enum logic [1:0] {
    TBL_NONE = 2'b00,
    TBL_POSTINC = 2'b01,
    TBL_POSTDEC = 2'b10,
    TBL_PREINC = 2'b11
} mid_tbl_e;

function automatic logic mid_is_cont(input logic [15:0] w);
    return w[`MID_TOP] == `MID_CONT;
endfunction

endpackage

// *** src/mid_fields_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface mid_fields_if import mid_pkg::*; ();
    logic [15:0] word;
    mid_class_e cls;
    mid_tbl_e tbl;
    logic is_cont, is_dword, has_file, dest_file, acc_sel, is_test;
    logic pc_change, fast, is_move, is_call, is_ret, is_tbl, is_lptr;
    logic [7:0] f;
    logic [2:0] bnum;
    logic [7:0] k;
    logic [1:0] ptr;
    logic [10:0] n;
    modport split(input word, output cls, tbl, is_cont, is_dword, has_file, dest_file, acc_sel, is_test,
                  pc_change, fast, is_move, is_call, is_ret, is_tbl, is_lptr, f, bnum, k, ptr, n);
    modport user(output word, input cls, tbl, is_cont, is_dword, has_file, dest_file, acc_sel, is_test,
                 pc_change, fast, is_move, is_call, is_ret, is_tbl, is_lptr, f, bnum, k, ptr, n);
endinterface
`default_nettype wire

// *** src/mid_phase_ctr.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mid_defines.svh"
module mid_phase_ctr import mid_pkg::*; #(
    parameter int PHASES = `MID_PHASES
) (
    input wire logic clk,
    input wire logic arst_n,
    output logic [1:0] phase,
    output logic last
);
    logic [1:0] ph_ff;
    logic [1:0] nxt_ph;

    if (PHASES != `MID_PHASES) begin : g_bad
        $error("mid_phase_ctr supports exactly four phases");
    end

    always_comb begin
        nxt_ph = (ph_ff == `MID_PH_Q4) ? `MID_PH_Q1 : ph_ff + 2'h1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_ff <= `MID_PH_Q1;
        end else begin
            ph_ff <= nxt_ph;
        end
    end

    assign phase = ph_ff;
    assign last = (ph_ff == `MID_PH_Q4);
endmodule
`default_nettype wire

// *** src/mid_word_split.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mid_defines.svh"
module mid_word_split import mid_pkg::*; (
    mid_fields_if.split fi
);
    always_comb begin
        logic [3:0] top;
        logic [3:0] sub;
        top = fi.word[`MID_TOP];
        sub = fi.word[`MID_SUB];
        fi.f = fi.word[`MID_F];
        fi.dest_file = fi.word[`MID_D_BIT];
        fi.acc_sel = fi.word[`MID_A_BIT];
        fi.bnum = fi.word[`MID_B];
        fi.k = fi.word[`MID_K];
        fi.ptr = fi.word[`MID_PTR];
        fi.n = fi.word[`MID_N];
        fi.tbl = mid_tbl_e'(fi.word[`MID_MM]);
        fi.is_cont = mid_is_cont(fi.word);
        fi.is_move = (top == `MID_OP_MOVE);
        fi.is_call = (top == `MID_OP_CALL);
        fi.is_lptr = (top == `MID_OP_LPTR);
        fi.is_ret = (top == `MID_OP_CTRL) && (sub == `MID_SUB_RET);
        fi.is_tbl = (top == `MID_OP_CTRL) && (sub == `MID_SUB_TBL);
        fi.is_test = (top == `MID_OP_BTEST);
        fi.fast = fi.is_call ? fi.word[`MID_CALL_S] : fi.word[`MID_RET_S];
        fi.is_dword = fi.is_move || fi.is_call || fi.is_lptr;
        fi.pc_change = fi.is_call || fi.is_ret || (top == `MID_OP_BRA);
        fi.has_file = ((top >= `MID_OP_BYTE_LO) && (top <= `MID_OP_BTEST)) || fi.is_move;
        if (((top >= `MID_OP_BYTE_LO) && (top <= `MID_OP_BYTE_HI)) || fi.is_move) begin
            fi.cls = CLS_BYTE;
        end else if ((top >= `MID_OP_BIT_LO) && (top <= `MID_OP_BTEST)) begin
            fi.cls = CLS_BIT;
        end else if (fi.is_lptr || (top == `MID_OP_LIT)) begin
            fi.cls = CLS_LIT;
        end else begin
            fi.cls = CLS_CTRL;
        end
    end
endmodule
`default_nettype wire

// *** src/mid_decode.sv ***
//
// Behaviour
// - Instructions are one 16-bit word except three that span two consecutive words.
// - Byte instructions give the datapath a file address, a destination bit and an access bit.
// - Destination 0 writes the accumulator and destination 1 writes the addressed file register.
// - Bit instructions give a file address, a bit number and the access bit.
// - Literal instructions give an immediate, maybe a pointer select, or nothing.
// - Control instructions give a program address, a fast-mode bit, a table mode, or nothing.
// - A continuation word has its four top bits all ones.
// - One cycle per instruction, plus a no-operation cycle on a true test or a program counter change.
// - Double-word instructions take two instruction cycles.
// - Each instruction cycle is four clock periods counted by a four-phase counter.
// - A file operand is always read first, then modified, then stored.
// - The forced read triggers read side effects in the file space before any write back.
// - Access bit 0 uses the fixed access bank and ignores the bank select register, 1 uses it.
// - Fast mode 1 saves or restores shadow copies on call or return, 0 leaves them.
// - Table mode picks no change, post-increment, post-decrement or pre-increment.
// - The file address field of byte and bit instructions is 8 bits wide.
`timescale 1ns/1ps
`default_nettype none
`include "mid_defines.svh"
module mid_decode import mid_pkg::*; (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [15:0] fetch_word,
    input wire logic [3:0] bank_select_register,
    input wire logic skip_true,
    output logic [1:0] q_phase,
    output mid_class_e exec_class,
    output logic [11:0] file_addr,
    output logic acc_sel,
    output logic [2:0] bit_num,
    output logic [11:0] literal,
    output logic [1:0] ptr_sel,
    output logic [19:0] prog_addr,
    output logic fast_mode,
    output mid_tbl_e tbl_mode,
    output logic rd_strobe,
    output logic wr_working_accumulator,
    output logic wr_file,
    output logic tbl_inc,
    output logic tbl_dec,
    output logic shadow_save,
    output logic shadow_restore,
    output logic pc_load,
    output logic nop_cycle,
    output logic word2_cycle
);
    mid_fields_if fi ();

    mid_state_e state_ff, nxt_state;
    logic [15:0] ir_ff, nxt_ir;
    logic [15:0] w2_ff, nxt_w2;
    logic ph_last;
    logic [3:0] bank;

    mid_class_e cls_ff, nxt_cls;
    mid_tbl_e tbl_ff, nxt_tbl;
    logic [11:0] addr_ff, nxt_addr;
    logic [11:0] lit_ff, nxt_lit;
    logic [19:0] prog_ff, nxt_prog;
    logic [2:0] bit_ff, nxt_bit;
    logic [1:0] ptr_ff, nxt_ptr;
    logic acc_ff, nxt_acc;
    logic fast_ff, nxt_fast;
    logic rd_ff, nxt_rd;
    logic working_accumulator_ff, nxt_working_accumulator;
    logic wfile_ff, nxt_wfile;
    logic inc_ff, nxt_inc;
    logic dec_ff, nxt_dec;
    logic save_ff, nxt_save;
    logic rest_ff, nxt_rest;
    logic pcl_ff, nxt_pcl;
    logic nop_ff, nxt_nop;
    logic w2c_ff, nxt_w2c;

    mid_phase_ctr #(
        .PHASES(`MID_PHASES)
    ) u_phase (
        .clk(clk),
        .arst_n(arst_n),
        .phase(q_phase),
        .last(ph_last)
    );

    assign fi.word = ir_ff;

    mid_word_split u_split (
        .fi(fi)
    );

    // Sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_ir = ir_ff;
        nxt_w2 = w2_ff;
        if (ph_last) begin
            case (state_ff)
                ST_EXEC: begin
                    if (fi.is_dword) begin
                        nxt_state = ST_WORD2;
                        nxt_w2 = fetch_word;
                    end else if (fi.pc_change || (fi.is_test && skip_true)) begin
                        nxt_state = ST_FLUSH;
                        nxt_ir = `MID_NOP_WORD;
                    end else begin
                        nxt_ir = fetch_word;
                    end
                end
                ST_WORD2: begin
                    if (fi.pc_change) begin
                        nxt_state = ST_FLUSH;
                        nxt_ir = `MID_NOP_WORD;
                    end else begin
                        nxt_state = ST_EXEC;
                        nxt_ir = fetch_word;
                    end
                end
                ST_FLUSH: begin
                    nxt_state = ST_EXEC;
                    nxt_ir = fetch_word;
                end
                default: begin
                    nxt_state = ST_EXEC;
                    nxt_ir = `MID_NOP_WORD;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_EXEC;
            ir_ff <= `MID_NOP_WORD;
            w2_ff <= `MID_NOP_WORD;
        end else begin
            state_ff <= nxt_state;
            ir_ff <= nxt_ir;
            w2_ff <= nxt_w2;
        end
    end

    assign bank = fi.acc_sel ? bank_select_register : `MID_ACC_BANK;

    // Datapath controls
    always_comb begin
        nxt_cls = fi.cls;
        nxt_tbl = fi.tbl;
        nxt_bit = fi.bnum;
        nxt_ptr = fi.ptr;
        nxt_acc = fi.acc_sel;
        nxt_fast = fi.fast;
        nxt_addr = fi.is_move ? ir_ff[`MID_FS] : {bank, fi.f};
        nxt_lit = fi.is_lptr ? {ir_ff[`MID_KHI], w2_ff[`MID_K]} : {`MID_ZERO4, fi.k};
        nxt_prog = fi.is_call ? {w2_ff[`MID_FS], fi.k} : {{9{fi.n[`MID_N_MSB]}}, fi.n};
        nxt_rd = 1'b0;
        nxt_working_accumulator = 1'b0;
        nxt_wfile = 1'b0;
        nxt_inc = 1'b0;
        nxt_dec = 1'b0;
        nxt_save = 1'b0;
        nxt_rest = 1'b0;
        nxt_pcl = 1'b0;
        nxt_nop = (state_ff == ST_FLUSH) || (state_ff == ST_EXEC && fi.is_cont);
        nxt_w2c = (state_ff == ST_WORD2);
        case (state_ff)
            ST_EXEC: begin
                if (!fi.is_cont) begin
                    if (q_phase == `MID_PH_Q2 && fi.has_file) begin
                        nxt_rd = 1'b1;
                    end
                    if (q_phase == `MID_PH_Q2 && fi.is_tbl && fi.tbl == TBL_PREINC) begin
                        nxt_inc = 1'b1;
                    end
                    if (ph_last) begin
                        if (fi.cls == CLS_BYTE && !fi.is_move) begin
                            nxt_wfile = fi.dest_file;
                            nxt_working_accumulator = !fi.dest_file;
                        end else if (fi.cls == CLS_BIT && !fi.is_test) begin
                            nxt_wfile = 1'b1;
                        end
                        if (fi.is_tbl) begin
                            nxt_inc = (fi.tbl == TBL_POSTINC);
                            nxt_dec = (fi.tbl == TBL_POSTDEC);
                        end
                        if (fi.pc_change && !fi.is_call) begin
                            nxt_pcl = 1'b1;
                        end
                        nxt_rest = fi.is_ret && fi.fast;
                    end
                end
            end
            ST_WORD2: begin
                if (fi.is_move) begin
                    nxt_addr = w2_ff[`MID_FS];
                end
                if (ph_last) begin
                    nxt_wfile = fi.is_move;
                    nxt_pcl = fi.is_call;
                    nxt_save = fi.is_call && fi.fast;
                end
            end
            default: begin
                nxt_cls = CLS_CTRL;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cls_ff <= CLS_CTRL;
            tbl_ff <= TBL_NONE;
            addr_ff <= 12'h000;
            lit_ff <= 12'h000;
            prog_ff <= 20'h0_0000;
            bit_ff <= 3'h0;
            ptr_ff <= 2'h0;
            acc_ff <= 1'b0;
            fast_ff <= 1'b0;
            rd_ff <= 1'b0;
            working_accumulator_ff <= 1'b0;
            wfile_ff <= 1'b0;
            inc_ff <= 1'b0;
            dec_ff <= 1'b0;
            save_ff <= 1'b0;
            rest_ff <= 1'b0;
            pcl_ff <= 1'b0;
            nop_ff <= 1'b1;
            w2c_ff <= 1'b0;
        end else begin
            cls_ff <= nxt_cls;
            tbl_ff <= nxt_tbl;
            addr_ff <= nxt_addr;
            lit_ff <= nxt_lit;
            prog_ff <= nxt_prog;
            bit_ff <= nxt_bit;
            ptr_ff <= nxt_ptr;
            acc_ff <= nxt_acc;
            fast_ff <= nxt_fast;
            rd_ff <= nxt_rd;
            working_accumulator_ff <= nxt_working_accumulator;
            wfile_ff <= nxt_wfile;
            inc_ff <= nxt_inc;
            dec_ff <= nxt_dec;
            save_ff <= nxt_save;
            rest_ff <= nxt_rest;
            pcl_ff <= nxt_pcl;
            nop_ff <= nxt_nop;
            w2c_ff <= nxt_w2c;
        end
    end

    assign exec_class = cls_ff;
    assign tbl_mode = tbl_ff;
    assign file_addr = addr_ff;
    assign literal = lit_ff;
    assign prog_addr = prog_ff;
    assign bit_num = bit_ff;
    assign ptr_sel = ptr_ff;
    assign acc_sel = acc_ff;
    assign fast_mode = fast_ff;
    assign rd_strobe = rd_ff;
    assign wr_working_accumulator = working_accumulator_ff;
    assign wr_file = wfile_ff;
    assign tbl_inc = inc_ff;
    assign tbl_dec = dec_ff;
    assign shadow_save = save_ff;
    assign shadow_restore = rest_ff;
    assign pc_load = pcl_ff;
    assign nop_cycle = nop_ff;
    assign word2_cycle = w2c_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_phase_wrap: assert property (
        q_phase == `MID_PH_Q4 |=> q_phase == `MID_PH_Q1 ##1 q_phase == `MID_PH_Q2 ##1 q_phase == `MID_PH_Q3
    ) else $error("phase counter did not cycle through four phases");

    a_dword_two: assert property (
        (state_ff == ST_EXEC && fi.is_dword && ph_last) |=> (state_ff == ST_WORD2) [*4] ##1 state_ff != ST_WORD2
    ) else $error("double word did not take exactly one extra cycle");

    a_flush_after: assert property (
        (state_ff == ST_EXEC && !fi.is_dword && (fi.pc_change || (fi.is_test && skip_true)) && ph_last)
        |=> (state_ff == ST_FLUSH) [*4] ##1 state_ff == ST_EXEC
    ) else $error("no single no-op cycle after branch or true test");

    a_single_one: assert property (
        (state_ff == ST_EXEC && !fi.is_dword && !fi.pc_change && !(fi.is_test && skip_true) && ph_last)
        |=> (state_ff == ST_EXEC) [*4]
    ) else $error("single word instruction took more than one cycle");

    a_cont_nop: assert property (
        (state_ff == ST_EXEC && fi.is_cont) |=> !rd_strobe && !wr_file && !wr_working_accumulator && !pc_load && nop_cycle
    ) else $error("lone continuation word changed state");

    a_read_first: assert property (
        (wr_file && !word2_cycle) |-> $past(rd_strobe, 2)
    ) else $error("file write without read two clocks earlier");

    a_dest_working_accumulator: assert property (
        wr_working_accumulator |-> !wr_file && exec_class == CLS_BYTE && !$past(fi.dest_file)
    ) else $error("accumulator written when destination selects file");

    a_access_bank: assert property (
        (rd_strobe && !acc_sel && !$past(fi.is_move)) |-> file_addr[11:8] == `MID_ACC_BANK
    ) else $error("access bank not used when access bit is clear");

    a_shadow_fast: assert property (
        (shadow_save || shadow_restore) |-> fast_mode && pc_load
    ) else $error("shadow copy touched without fast mode");

    a_tbl_step: assert property (
        tbl_dec |-> tbl_mode == TBL_POSTDEC && !tbl_inc
    ) else $error("table decrement without post-decrement mode");

    c_dword: cover property (state_ff == ST_WORD2 && ph_last);
    c_flush: cover property (state_ff == ST_FLUSH && ph_last);
    c_cont: cover property (state_ff == ST_EXEC && fi.is_cont && ph_last);
    c_rmw: cover property (rd_strobe ##2 wr_file);
endmodule
`default_nettype wire

// *** verification/mid_decode_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module mid_decode_tb import mid_pkg::*; ();
    localparam logic [6:0] m_working_accumulator = 7'h40;
    localparam logic [6:0] m_file = 7'h20;
    localparam logic [6:0] m_pc = 7'h10;
    localparam logic [6:0] m_save = 7'h08;
    localparam logic [6:0] m_rest = 7'h04;
    localparam logic [6:0] m_tinc = 7'h02;
    localparam logic [6:0] m_tdec = 7'h01;
    logic clk;
    logic arst_n;
    logic [15:0] fetch_word;
    logic [3:0] bank_select_register;
    logic skip_true;
    logic [1:0] q_phase;
    mid_class_e exec_class;
    logic [11:0] file_addr;
    logic acc_sel;
    logic [2:0] bit_num;
    logic [11:0] literal;
    logic [1:0] ptr_sel;
    logic [19:0] prog_addr;
    logic fast_mode;
    mid_tbl_e tbl_mode;
    logic rd_strobe, wr_working_accumulator, wr_file, tbl_inc, tbl_dec;
    logic shadow_save, shadow_restore, pc_load, nop_cycle, word2_cycle;
    int n_mismatch;
    int num_checks;
    // Values captured in one instruction cycle
    logic [6:0] q0;
    logic rd, pre, nop, w2, as, ff;
    mid_class_e cls;
    mid_tbl_e tm;
    logic [11:0] fa, lit;
    logic [2:0] bn;
    logic [1:0] ps;
    logic [19:0] pa;
    logic [6:0] tq [4];

    mid_decode i_mid_decode (
        .clk(clk), .arst_n(arst_n), .fetch_word(fetch_word),
        .bank_select_register(bank_select_register), .skip_true(skip_true),
        .q_phase(q_phase), .exec_class(exec_class), .file_addr(file_addr), .acc_sel(acc_sel),
        .bit_num(bit_num), .literal(literal), .ptr_sel(ptr_sel), .prog_addr(prog_addr),
        .fast_mode(fast_mode), .tbl_mode(tbl_mode), .rd_strobe(rd_strobe), .wr_working_accumulator(wr_working_accumulator),
        .wr_file(wr_file), .tbl_inc(tbl_inc), .tbl_dec(tbl_dec), .shadow_save(shadow_save),
        .shadow_restore(shadow_restore), .pc_load(pc_load), .nop_cycle(nop_cycle),
        .word2_cycle(word2_cycle)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Present one word at the end of Q4 and capture the following four clocks
    task automatic run(input logic [15:0] w, input logic sk);
        int n;
        n = 0;
        while (q_phase !== 2'h3 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (q_phase !== 2'h3) begin
            n_mismatch++;
            final_report();
        end
        fetch_word = w;
        skip_true = sk;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1;
            `CHK(q_phase, i[1:0])
            if (i == 0) begin
                q0 = {wr_working_accumulator, wr_file, pc_load, shadow_save, shadow_restore, tbl_inc, tbl_dec};
            end else if (i == 1) begin
                cls = exec_class;
                fa = file_addr;
                as = acc_sel;
                bn = bit_num;
                lit = literal;
                ps = ptr_sel;
                pa = prog_addr;
                ff = fast_mode;
                tm = tbl_mode;
                nop = nop_cycle;
                w2 = word2_cycle;
            end else if (i == 2) begin
                rd = rd_strobe;
                pre = tbl_inc;
            end
        end
    endtask

    task automatic check_reset();
        `CHK(q_phase, 2'h0)
        `CHK(nop_cycle, 1'b1)
        `CHK(exec_class, CLS_CTRL)
        `CHK({rd_strobe, wr_working_accumulator, wr_file, pc_load, word2_cycle}, 5'h00)
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    initial begin
        arst_n = 1'b0;
        fetch_word = 16'hffff;
        bank_select_register = 4'h7;
        skip_true = 1'b0;
        n_mismatch = 0;
        num_checks = 0;
        tq = '{7'h00, m_tinc, m_tdec, 7'h00};
        repeat (8) @(posedge clk);
        #1;
        check_reset();
        arst_n = 1'b1;
        // Byte operations, both destinations and both access modes
        run(16'h13a5, 1'b0);
        `CHK(cls, CLS_BYTE)
        `CHK(fa, 12'h7a5)
        `CHK(as, 1'b1)
        `CHK(rd, 1'b1)
        run(16'h20c3, 1'b0);
        `CHK(q0, m_file)
        `CHK(fa, 12'h0c3)
        `CHK(as, 1'b0)
        `CHK(rd, 1'b1)
        // Bit operation with write back
        run(16'h8b5a, 1'b0);
        `CHK(q0, m_working_accumulator)
        `CHK(cls, CLS_BIT)
        `CHK(bn, 3'h5)
        `CHK(fa, 12'h75a)
        `CHK(rd, 1'b1)
        run(16'hb042, 1'b0);
        `CHK(q0, m_file)
        `CHK(cls, CLS_LIT)
        `CHK(lit, 12'h042)
        `CHK(rd, 1'b0)
        // Bit test, true then false; the test result comes with the next word
        run(16'ha3ff, 1'b0);
        `CHK(rd, 1'b1)
        run(16'h1000, 1'b1);
        `CHK(q0, 7'h00)
        `CHK(nop, 1'b1)
        `CHK(rd, 1'b0)
        run(16'ha3ff, 1'b0);
        run(16'hb011, 1'b0);
        `CHK(nop, 1'b0)
        `CHK(cls, CLS_LIT)
        // Branch with negative offset
        run(16'hd400, 1'b0);
        `CHK(cls, CLS_CTRL)
        `CHK(pa, 20'hf_fc00)
        run(16'hffff, 1'b0);
        `CHK(q0, m_pc)
        `CHK(nop, 1'b1)
        // Calls, fast and plain
        run(16'he134, 1'b0);
        `CHK(ff, 1'b1)
        `CHK(w2, 1'b0)
        run(16'hf567, 1'b0);
        `CHK(w2, 1'b1)
        `CHK(pa, 20'h5_6734)
        run(16'hffff, 1'b0);
        `CHK(q0, m_pc | m_save)
        `CHK(nop, 1'b1)
        run(16'he034, 1'b0);
        `CHK(ff, 1'b0)
        run(16'hf000, 1'b0);
        `CHK(pa, 20'h0_0034)
        run(16'hffff, 1'b0);
        `CHK(q0, m_pc)
        // Returns, fast and plain
        run(16'h0201, 1'b0);
        `CHK(ff, 1'b1)
        run(16'hffff, 1'b0);
        `CHK(q0, m_pc | m_rest)
        run(16'h0200, 1'b0);
        `CHK(q0, 7'h00)
        run(16'hffff, 1'b0);
        `CHK(q0, m_pc)
        // Every table mode
        for (int m = 0; m < 4; m++) begin
            run({14'h0040, m[1:0]}, 1'b0);
            `CHK(tm, mid_tbl_e'(m[1:0]))
            `CHK(pre, (m == 3))
            run(16'hb000, 1'b0);
            `CHK(q0, tq[m])
        end
        // Lone continuation word
        run(16'hf123, 1'b0);
        `CHK(nop, 1'b1)
        `CHK(rd, 1'b0)
        `CHK(w2, 1'b0)
        run(16'hb000, 1'b0);
        `CHK(q0, 7'h00)
        // Pointer load and move, both double words
        run(16'h602a, 1'b0);
        run(16'hf0bc, 1'b0);
        `CHK(w2, 1'b1)
        `CHK(lit, 12'habc)
        `CHK(ps, 2'h2)
        run(16'hc123, 1'b0);
        `CHK(w2, 1'b0)
        `CHK(nop, 1'b0)
        `CHK(fa, 12'h123)
        `CHK(rd, 1'b1)
        run(16'hf456, 1'b0);
        `CHK(w2, 1'b1)
        `CHK(fa, 12'h456)
        // Reset in mid-run, then resume
        arst_n = 1'b0;
        #1;
        check_reset();
        @(posedge clk);
        #1;
        arst_n = 1'b1;
        run(16'h13a5, 1'b0);
        `CHK(fa, 12'h7a5)
        `CHK(rd, 1'b1)
        run(16'hffff, 1'b0);
        `CHK(q0, m_file)
        final_report();
    end
endmodule
`default_nettype wire
